// file: include/adc_chg_usb_pkg.sv
// Package of offsets, field layouts, reset values and carriers for the ADC, charger and USB ID register slice.
`default_nettype none
package adc_chg_usb_pkg;

  // Register port widths: six address bits reach register indices up to 63, every register is 24 bits.
  localparam int unsigned REG_AW = 6;
  localparam int unsigned REG_DW = 24;

  // Register indices as printed; the register port addresses registers by index.
  localparam logic [5:0] OFS_GEN_ID  = 6'h2E;
  localparam logic [5:0] OFS_SEC_RES = 6'h2F;
  localparam logic [5:0] OFS_CHARGER = 6'h30;
  localparam logic [5:0] OFS_USB_ID  = 6'h31;

  // Generation identifier field position and width.
  localparam int unsigned GEN_ID_LSB = 6;
  localparam int unsigned GEN_ID_W   = 3;

  // Secondary conversion result fields: two 10-bit results.
  localparam int unsigned RES_W    = 10;
  localparam int unsigned RES1_LSB = 2;
  localparam int unsigned RES2_LSB = 14;

  // Charger register reset value and the mask of bits that software may write.
  localparam logic [23:0] CHARGER_RESET = 24'h400003;
  localparam logic [23:0] CHARGER_WMASK = 24'hFFBFFF;

  // Charge voltage and current values that apply when software programming is not allowed.
  localparam logic [2:0] VOLT_RESET = 3'h3;
  localparam logic [3:0] CURR_RESET = 4'h0;

  // USB ID register layout: a spare bit and the pull-up source select bit.
  localparam int unsigned USB_SPARE_BIT = 6;
  localparam int unsigned ID_PU_BIT     = 22;
  localparam logic [23:0] USB_RESET     = 24'h000040;
  localparam logic [23:0] USB_WMASK     = 24'h400040;

  // Charger configuration word, most significant bit first.
  typedef struct packed {
    logic       vi_program_allow;      // Bit 23: software voltage and current take effect.
    logic       cycling_off;           // Bit 22: disables charge cycling.
    logic       auto_charge_inhibit;   // Bit 21: no automatic charging while on.
    logic       charger_fsm_restart;   // Bit 20: restart request, cleared by the charger.
    logic       charge_timer_reset;    // Bit 19: timer reset request, cleared by the charger.
    logic       charge_led_en;         // Bit 18: charge indicator enable.
    logic       power_limit_off;       // Bit 17: power limiter disable.
    logic [1:0] power_limit;           // Bits 16:15: power limiter setting.
    logic       unused14;              // Bit 14: not writable, reads zero.
    logic       reverse_mode;          // Bit 13: reverse mode enable.
    logic       spare12;               // Bit 12: spare storage.
    logic       batt_switch_ctrl;      // Bit 11: battery switch control.
    logic       batt_switch_override;  // Bit 10: lets bit 11 steer the battery switch.
    logic       thermistor_check_off;  // Bit 9: disables thermistor check.
    logic       low_power_boot_ack;    // Bit 8: acknowledges low-power boot.
    logic       trickle_enable;        // Bit 7: internal trickle current on.
    logic [3:0] charge_current_sel;    // Bits 6:3: main charger DAC current.
    logic [2:0] charge_voltage_sel;    // Bits 2:0: regulator output voltage.
  } charger_cfg_s;

  // One register access from the host side.
  typedef struct packed {
    logic       sel;    // Access strobe, one cycle per access.
    logic       wr;     // High for a write, low for a read.
    logic [5:0] addr;   // Register index.
    logic [23:0] wdata; // Write data.
  } reg_req_s;

  // Levels that steer the analog charger.
  typedef struct packed {
    logic [2:0] voltage;             // Applied regulator voltage code.
    logic [3:0] current;             // Applied DAC current code.
    logic       trickle_on;          // Trickle current source on.
    logic       thermistor_check_on; // Thermistor check active.
    logic       auto_charge_go;      // Automatic charging permitted now.
    logic       fsm_restart;         // Restart request level.
    logic       timer_reset;         // Timer reset request level.
    logic       id_pullup_alt;       // USB ID pull-up source select.
  } charger_drive_s;

endpackage : adc_chg_usb_pkg
`default_nettype wire

// file: core/sec_result_hold.sv
// Holding register for the two secondary conversion results, deliberately free of reset.
`default_nettype none
module sec_result_hold (
  // Clock.
  input  wire logic                                   clk,
  // Conversion results from the converter.
  input  wire logic                                   res_load,
  input  wire logic [adc_chg_usb_pkg::RES_W-1:0]      res_first,
  input  wire logic [adc_chg_usb_pkg::RES_W-1:0]      res_second,
  // Assembled register word.
  output logic      [adc_chg_usb_pkg::REG_DW-1:0]     res_word
);
  import adc_chg_usb_pkg::*;

  // The whole state of this module: the assembled result word.
  typedef struct packed {
    logic [REG_DW-1:0] word;
  } hold_s;

  hold_s hold_q;  // Held results.
  hold_s hold_d;  // Next held results.

  // Loads both results at once so the pair is always coherent; spare bits stay zero.
  always_comb begin
    hold_d = hold_q;
    if (res_load) begin
      hold_d.word                             = '0;
      hold_d.word[RES1_LSB +: RES_W]          = res_first;   // RQ1
      hold_d.word[RES2_LSB +: RES_W]          = res_second;  // RQ2
    end
  end

  // No reset here: results survive any reset, and read as unknown until the first conversion.
  always_ff @(posedge clk) begin
    hold_q <= hold_d;  // RQ1
  end

  assign res_word = hold_q.word;

endmodule : sec_result_hold
`default_nettype wire

// file: core/adc_charger_usb_regs.sv
// Register slice holding generation identity, secondary results, charger configuration and USB ID control.
// Function
// [RQ1] First secondary result in bits 2-11, unreset.
// [RQ2] Second secondary result in bits 14-23, unreset.
// [RQ3] Voltage field bits 0-2, resets to 3.
// [RQ4] Current field bits 3-6, hardware-writable, resets zero.
// [RQ5] Bit 7 turns trickle current on.
// [RQ6] Bit 9 disables thermistor check.
// [RQ7] Bit 20 restarts charger, hardware clears it.
// [RQ8] Bit 21 blocks automatic charging while on.
// [RQ9] Bit 23 lets programmed voltage/current apply.
// [RQ10] USB bit 22 selects ID pull-up source.
// [RQ11] Software drives secondary conversion via control bit; no such bit here, results load on sec_res_load.
// [RQ12] Unused bits read zero, ignore writes.
// [RQ13] Identity bits 6-8 fixed, read-only, unreset.
`default_nettype none
module adc_charger_usb_regs #(
  parameter logic [2:0] GEN_ID_VALUE = 3'h2  // Generation identifier; the value is arbitrary.
) (
  // Clock and synchronous active-low reset.
  input  wire logic                            clk,
  input  wire logic                            rstn,
  // Register access port.
  input  wire adc_chg_usb_pkg::reg_req_s       reg_req,
  output logic      [23:0]                     reg_rdata,
  output logic                                 reg_rvalid,
  // Secondary conversion results from the converter.
  input  wire logic                            sec_res_load,
  input  wire logic [9:0]                      sec_res_first,
  input  wire logic [9:0]                      sec_res_second,
  // Updates made by the charger itself, and the device power-on level.
  input  wire logic                            hw_current_we,
  input  wire logic [3:0]                      hw_current_val,
  input  wire logic                            hw_restart_done,
  input  wire logic                            hw_timer_reset_done,
  input  wire logic                            power_on,
  // Configuration and steering levels towards the analog charger.
  output adc_chg_usb_pkg::charger_cfg_s        charger_cfg,
  output adc_chg_usb_pkg::charger_drive_s      charger_drive
);
  import adc_chg_usb_pkg::*;

  // The whole state of the register slice except the secondary results, which u_sec_hold keeps.
  typedef struct packed {
    charger_cfg_s chg;      // Charger configuration register.
    logic         idpu;     // USB ID pull-up source select.
    logic         usb_spare; // USB spare storage bit.
    logic [23:0]  rdata;    // Read data, held until the next read.
    logic         rvalid;   // One-cycle read answer strobe.
  } regs_s;

  regs_s        regs_q;     // Registered state.
  regs_s        regs_d;     // Next state.
  logic [23:0]  sec_word;   // Secondary results word.
  logic [23:0]  read_word;  // Selected read value.
  charger_cfg_s wr_chg;     // Charger write data after masking.
  logic         wr_chg_hit; // Write to the charger register.
  logic         wr_usb_hit; // Write to the USB ID register.
  logic         rd_hit;     // Read access this cycle.

  // Secondary results are held in their own unreset storage.
  sec_result_hold u_sec_hold (
    .clk        (clk),
    .res_load   (sec_res_load),
    .res_first  (sec_res_first),
    .res_second (sec_res_second),
    .res_word   (sec_word)
  );

  // Decodes the access strobe into register hits.
  assign wr_chg_hit = reg_req.sel && reg_req.wr && (reg_req.addr == OFS_CHARGER);
  assign wr_usb_hit = reg_req.sel && reg_req.wr && (reg_req.addr == OFS_USB_ID);
  assign rd_hit     = reg_req.sel && !reg_req.wr;
  assign wr_chg     = charger_cfg_s'(reg_req.wdata & CHARGER_WMASK);  // RQ12

  // Read multiplexer; any index outside this slice returns zero.
  always_comb begin
    read_word = '0;
    unique case (reg_req.addr)
      OFS_GEN_ID: begin
        read_word[GEN_ID_LSB +: GEN_ID_W] = GEN_ID_VALUE;  // RQ13
      end
      OFS_SEC_RES: begin
        read_word = sec_word;  // RQ1 RQ2
      end
      OFS_CHARGER: begin
        read_word = regs_q.chg & CHARGER_WMASK;  // RQ12
      end
      OFS_USB_ID: begin
        read_word[ID_PU_BIT]     = regs_q.idpu;
        read_word[USB_SPARE_BIT] = regs_q.usb_spare;
      end
      default: begin
        read_word = '0;  // RQ12
      end
    endcase
  end

  // Next-state logic: software writes, charger updates and read capture.
  always_comb begin
    regs_d        = regs_q;
    regs_d.rvalid = rd_hit;
    // A read captures the selected word; it stays until the next read.
    if (rd_hit) begin
      regs_d.rdata = read_word;
    end
    // Charger clears its request bits once served.
    if (hw_restart_done) begin
      regs_d.chg.charger_fsm_restart = 1'b0;
    end
    if (hw_timer_reset_done) begin
      regs_d.chg.charge_timer_reset = 1'b0;
    end
    // The charger may adjust its own current setting.
    if (hw_current_we) begin
      regs_d.chg.charge_current_sel = hw_current_val;  // RQ4
    end
    // A software write overrides; a written one beats a charger clear in the same cycle.
    if (wr_chg_hit) begin
      regs_d.chg = wr_chg;  // RQ3 RQ4 RQ5 RQ6 RQ8 RQ9
      if (!wr_chg.charger_fsm_restart && hw_restart_done) begin
        regs_d.chg.charger_fsm_restart = 1'b0;  // RQ7
      end
      if (!wr_chg.charge_timer_reset && hw_timer_reset_done) begin
        regs_d.chg.charge_timer_reset = 1'b0;
      end
    end
    // USB ID register: only the select and the spare bit store.
    if (wr_usb_hit) begin
      regs_d.idpu      = reg_req.wdata[ID_PU_BIT];  // RQ10
      regs_d.usb_spare = reg_req.wdata[USB_SPARE_BIT];
    end
  end

  // State register with synchronous reset to the documented defaults.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regs_q.chg       <= charger_cfg_s'(CHARGER_RESET);  // RQ3
      regs_q.idpu      <= USB_RESET[ID_PU_BIT];
      regs_q.usb_spare <= USB_RESET[USB_SPARE_BIT];
      regs_q.rdata     <= '0;
      regs_q.rvalid    <= 1'b0;
    end else begin
      regs_q <= regs_d;
    end
  end

  // Register outputs.
  assign reg_rdata   = regs_q.rdata;
  assign reg_rvalid  = regs_q.rvalid;
  assign charger_cfg = regs_q.chg;

  // Steering levels derived from the stored configuration.
  always_comb begin
    charger_drive                     = '0;
    // Programmed voltage and current only apply while allowed; otherwise defaults hold.
    charger_drive.voltage             = regs_q.chg.vi_program_allow ? regs_q.chg.charge_voltage_sel
                                                                    : VOLT_RESET;  // RQ9
    charger_drive.current             = regs_q.chg.vi_program_allow ? regs_q.chg.charge_current_sel
                                                                    : CURR_RESET;  // RQ9
    charger_drive.trickle_on          = regs_q.chg.trickle_enable;        // RQ5
    charger_drive.thermistor_check_on = !regs_q.chg.thermistor_check_off; // RQ6
    charger_drive.auto_charge_go      = !(regs_q.chg.auto_charge_inhibit && power_on);  // RQ8
    charger_drive.fsm_restart         = regs_q.chg.charger_fsm_restart;   // RQ7
    charger_drive.timer_reset         = regs_q.chg.charge_timer_reset;
    charger_drive.id_pullup_alt       = regs_q.idpu;                      // RQ10
  end

  // A read of the results word returns the first result in its field.
  a_sec_first_read: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    (rd_hit && reg_req.addr == OFS_SEC_RES) |=> reg_rdata[11:2] == $past(sec_word[11:2]) && reg_rvalid)
    else $error("first secondary result not returned");

  // A read of the results word returns the second result in its field.
  a_sec_second_read: assert property (@(posedge clk) disable iff (!rstn) // RQ2
    (rd_hit && reg_req.addr == OFS_SEC_RES) |=> reg_rdata[23:14] == $past(sec_word[23:14]))
    else $error("second secondary result not returned");

  // After reset release the voltage field holds three and current zero.
  a_chg_reset_val: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    $rose(rstn) |-> charger_cfg.charge_voltage_sel == VOLT_RESET && charger_cfg.charge_current_sel == CURR_RESET)
    else $error("charger fields not at reset value");

  // A charger current update without a software write lands next cycle.
  a_hw_current: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    (hw_current_we && !wr_chg_hit) |=> charger_cfg.charge_current_sel == $past(hw_current_val))
    else $error("charger current update lost");

  // Trickle output follows a written bit seven one cycle later.
  a_trickle_write: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    wr_chg_hit |=> charger_drive.trickle_on == $past(reg_req.wdata[7]))
    else $error("trickle enable does not follow write");

  // A written thermistor disable bit switches the check level one cycle later.
  a_therm_check: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    wr_chg_hit |=> charger_drive.thermistor_check_on == !$past(wr_chg.thermistor_check_off))
    else $error("thermistor check level wrong");

  // A written restart survives a same-cycle clear from the charger.
  a_restart_set: assert property (@(posedge clk) disable iff (!rstn) // RQ7
    (wr_chg_hit && reg_req.wdata[20]) |=> charger_drive.fsm_restart)
    else $error("restart request lost");

  // Inhibit while powered blocks automatic charging.
  a_auto_block: assert property (@(posedge clk) disable iff (!rstn) // RQ8
    (charger_cfg.auto_charge_inhibit && power_on) |-> !charger_drive.auto_charge_go)
    else $error("automatic charging not inhibited");

  // Without permission the applied voltage and current stay at defaults.
  a_vi_gate: assert property (@(posedge clk) disable iff (!rstn) // RQ9
    !charger_cfg.vi_program_allow |-> charger_drive.voltage == VOLT_RESET && charger_drive.current == CURR_RESET)
    else $error("programmed voltage or current applied without permission");

  // The pull-up select follows the written bit.
  a_idpu_write: assert property (@(posedge clk) disable iff (!rstn) // RQ10
    wr_usb_hit |=> charger_drive.id_pullup_alt == $past(reg_req.wdata[ID_PU_BIT]))
    else $error("pull-up select not stored");

  // Reserved USB bits always read zero.
  a_usb_reserved: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    (rd_hit && reg_req.addr == OFS_USB_ID) |=> (reg_rdata & ~USB_WMASK) == 24'h000000)
    else $error("reserved usb bits not zero");

  // The identity register reads the fixed generation value only.
  a_gen_id_read: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    (rd_hit && reg_req.addr == OFS_GEN_ID) |=> reg_rdata == (24'(GEN_ID_VALUE) << GEN_ID_LSB))
    else $error("generation identifier wrong");

endmodule : adc_charger_usb_regs
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the ADC result, charger and USB ID register slice.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_chg_usb_pkg::*;

  // Generation identifier handed to the design; the value is arbitrary.
  localparam logic [2:0] GEN = 3'h5;

  // One table row: a write, then a read back of the same index.
  typedef struct packed {
    logic [5:0]  addr;   // Register index.
    logic [23:0] wdata;  // Value written.
    logic [23:0] exp;    // Value expected on the read back.
  } row_s;

  logic           clk;       // System clock.
  logic           rstn;      // Synchronous reset, active low.
  reg_req_s       req;       // Register access request.
  logic [23:0]    rdata;     // Read data from the design.
  logic           rvalid;    // Read answer strobe.
  logic           res_load;  // Converter result load pulse.
  logic [9:0]     res_a;     // First converter result.
  logic [9:0]     res_b;     // Second converter result.
  logic           cur_we;    // Charger update of the current field.
  logic [3:0]     cur_val;   // Current value written by the charger.
  logic           rst_done;  // Charger finished its restart.
  logic           tmr_done;  // Charger finished its timer reset.
  logic           pwr_on;    // Device powered on.
  charger_cfg_s   cfg;       // Charger register as seen at the port.
  charger_drive_s drv;       // Steering levels towards the charger.
  int             fails;     // Mismatches seen.
  int             n_tests;   // Comparisons made.
  logic [23:0]    got;       // Last word read.
  row_s           rows [6];  // Ordinary write and read back cases.

  // Design under test.
  adc_charger_usb_regs #(.GEN_ID_VALUE(GEN)) i_dut (
    .clk                 (clk),
    .rstn                (rstn),
    .reg_req             (req),
    .reg_rdata           (rdata),
    .reg_rvalid          (rvalid),
    .sec_res_load        (res_load),
    .sec_res_first       (res_a),
    .sec_res_second      (res_b),
    .hw_current_we       (cur_we),
    .hw_current_val      (cur_val),
    .hw_restart_done     (rst_done),
    .hw_timer_reset_done (tmr_done),
    .power_on            (pwr_on),
    .charger_cfg         (cfg),
    .charger_drive       (drv)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One register access; the strobe is dropped at the edge that takes it.
  task automatic acc(input logic w, input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    req <= '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge clk);
    req.sel <= 1'b0;
    @(negedge clk);
    got = rdata;
    // A read is answered one cycle later, a write never.
    check({23'h0, rvalid}, {23'h0, ~w});
  endtask : acc

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial begin
    rstn = 1'b0;
    req = '0;
    res_load = 1'b0;
    res_a = 10'h0;
    res_b = 10'h0;
    cur_we = 1'b0;
    cur_val = 4'h0;
    rst_done = 1'b0;
    tmr_done = 1'b0;
    pwr_on = 1'b1;
    fails = 0;
    n_tests = 0;
    rows = '{'{OFS_CHARGER, 24'hFFFFFF, 24'hFFBFFF}, '{OFS_CHARGER, 24'h000000, 24'h000000},
             '{OFS_USB_ID, 24'hFFFFFF, 24'h400040}, '{OFS_USB_ID, 24'h000000, 24'h000000},
             '{OFS_GEN_ID, 24'hFFFFFF, {15'h0, GEN, 6'h0}}, '{6'h3F, 24'hFFFFFF, 24'h000000}};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Reset values of the charger, USB ID and identity registers and of the steering levels.
    acc(1'b0, OFS_CHARGER, 24'h0);
    check(got, 24'h400003);
    acc(1'b0, OFS_USB_ID, 24'h0);
    check(got, 24'h000040);
    acc(1'b0, OFS_GEN_ID, 24'h0);
    check(got, {15'h0, GEN, 6'h0});
    check(24'(drv), 24'({3'h3, 4'h0, 6'b011000}));
    $display("test reset values done");
    // Table of writes with read back, reserved bits and an unmapped index among them.
    foreach (rows[i]) begin
      acc(1'b1, rows[i].addr, rows[i].wdata);
      acc(1'b0, rows[i].addr, 24'h0);
      check(got, rows[i].exp);
    end
    $display("test table done");
    // Controls with programming not allowed, then allowed: applied voltage and current stay at reset codes until bit 23 is written.
    acc(1'b1, OFS_CHARGER, 24'h3002B4);
    check(24'(drv), 24'({3'h3, 4'h0, 6'b100100}));
    @(posedge clk);
    pwr_on <= 1'b0;
    @(negedge clk);
    check({23'h0, drv.auto_charge_go}, 24'h1);
    acc(1'b1, OFS_USB_ID, 24'h400000);
    acc(1'b1, OFS_CHARGER, 24'hB002B4);
    check(24'(drv), 24'({3'h4, 4'h6, 6'b101101}));
    $display("test steering levels done");
    // The charger clears the restart request and then updates the current field.
    @(posedge clk);
    rst_done <= 1'b1;
    @(posedge clk);
    rst_done <= 1'b0;
    @(negedge clk);
    check(24'(cfg), 24'hA002B4);
    @(posedge clk);
    cur_we <= 1'b1;
    cur_val <= 4'h9;
    @(posedge clk);
    cur_we <= 1'b0;
    @(negedge clk);
    check(24'(cfg), 24'hA002CC);
    check(24'(drv.current), 24'h9);
    // Software write in the same cycle as a charger update takes precedence.
    fork
      acc(1'b1, OFS_CHARGER, 24'h800000);
      begin
        @(posedge clk);
        cur_we <= 1'b1;
        cur_val <= 4'hF;
        @(posedge clk);
        cur_we <= 1'b0;
      end
    join
    check(24'(cfg), 24'h800000);
    // Written request bits win over done pulses in the same cycle; a later pulse clears only its own bit.
    fork
      acc(1'b1, OFS_CHARGER, 24'h980000);
      begin
        @(posedge clk);
        rst_done <= 1'b1;
        tmr_done <= 1'b1;
        @(posedge clk);
        rst_done <= 1'b0;
        tmr_done <= 1'b0;
      end
    join
    check(24'(cfg), 24'h980000);
    @(posedge clk);
    tmr_done <= 1'b1;
    @(posedge clk);
    tmr_done <= 1'b0;
    @(negedge clk);
    check(24'(cfg), 24'h900000);
    check({23'h0, drv.fsm_restart}, 24'h1);
    $display("test charger updates done");
    // Conversion results load together, ignore writes and survive a reset.
    @(posedge clk);
    res_load <= 1'b1;
    res_a <= 10'h3FF;
    res_b <= 10'h2A5;
    @(posedge clk);
    res_load <= 1'b0;
    acc(1'b1, OFS_SEC_RES, 24'h000000);
    acc(1'b0, OFS_SEC_RES, 24'h0);
    check(got, {10'h2A5, 2'b00, 10'h3FF, 2'b00});
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    acc(1'b0, OFS_SEC_RES, 24'h0);
    check(got, {10'h2A5, 2'b00, 10'h3FF, 2'b00});
    acc(1'b0, OFS_CHARGER, 24'h0);
    check(got, 24'h400003);
    acc(1'b0, OFS_GEN_ID, 24'h0);
    check(got, {15'h0, GEN, 6'h0});
    $display("test results and second reset done");
    wrap_up();
  end

endmodule : tb_top
`default_nettype wire
